// [core/wcu_pkg.sv]
// Package: constants and types for the upper wetting current configuration block
package wcu_pkg;
  localparam logic [7:0]  WCU_REG_INDEX   = 8'h1E;
  localparam logic [9:0]  WCU_REG_ADDR    = 10'h078;
  localparam logic [23:0] WCU_RESET_VAL   = 24'h000000;
  localparam logic [23:0] WCU_WRITE_MASK  = 24'h7FFFFF;
  localparam int          WCU_SINK_OFF_BIT = 22;
  localparam int          WCU_SRC_OFF_BIT  = 21;
  localparam int          WCU_FIELDS      = 7;
  localparam int          WCU_INPUTS      = 12;
  localparam logic [1:0]  WCU_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  WCU_RESP_SLVERR = 2'h2;
  localparam logic [2:0]  WCU_CODE_10MA   = 3'h4;
  // One-hot current levels
  localparam logic [5:0]  WCU_LVL_OFF  = 6'h01;
  localparam logic [5:0]  WCU_LVL_1MA  = 6'h02;
  localparam logic [5:0]  WCU_LVL_2MA  = 6'h04;
  localparam logic [5:0]  WCU_LVL_5MA  = 6'h08;
  localparam logic [5:0]  WCU_LVL_10MA = 6'h10;
  localparam logic [5:0]  WCU_LVL_15MA = 6'h20;

  typedef enum logic [1:0] {
    WCU_W_IDLE = 2'h1,
    WCU_W_RESP = 2'h2
  } wcu_wstate_t;

  typedef enum logic [1:0] {
    WCU_R_IDLE = 2'h1,
    WCU_R_DATA = 2'h2
  } wcu_rstate_t;

  typedef struct packed {
    logic [9:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [9:0]  araddr;
    logic        arvalid;
    logic        rready;
  } wcu_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } wcu_axi_rsp_t;

  typedef struct packed {
    wcu_wstate_t  wst;
    wcu_rstate_t  rst;
    logic         aw_got;
    logic [9:0]   aw_addr;
    logic         w_got;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic [23:0]  cfg;
    wcu_axi_rsp_t rsp;
    logic [71:0]  level;
  } wcu_state_t;
endpackage

// [core/wcu_top.sv]
// Top: AXI4-Lite register and per-input wetting current level decode
`timescale 1ns/1ps
module wcu_top (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  input  wire wcu_pkg::wcu_axi_req_t axi_req_in,
  output wcu_pkg::wcu_axi_rsp_t      axi_rsp_out,
  input  wire logic [23:0]           sel_sink_in,
  input  wire logic [23:0]           closed_in,
  input  wire logic                  continuous_in,
  output logic [71:0]                level_out
);
  import wcu_pkg::*;

  wcu_state_t s_ff;
  wcu_state_t nxt_s;

  ////////////////////////////////////////////////////////////////////////
  // Field of input n (n = 12..23)
  function automatic logic [2:0] field_of(input logic [23:0] cfg, input int n);
    logic [2:0] f;
    f = 3'h0;
    if (n == 23) begin
      f = cfg[20:18];
    end else if (n == 22) begin
      f = cfg[17:15];
    end else begin
      f = cfg[3*((n-12)/2) +: 3];
    end
    return f;
  endfunction

  // Code to one-hot level
  function automatic logic [5:0] decode(input logic [2:0] c);
    logic [5:0] l;
    l = WCU_LVL_15MA;
    case (c)
      3'h0: l = WCU_LVL_OFF;
      3'h1: l = WCU_LVL_1MA;
      3'h2: l = WCU_LVL_2MA;
      3'h3: l = WCU_LVL_5MA;
      3'h4: l = WCU_LVL_10MA;
      default: l = WCU_LVL_15MA;
    endcase
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [2:0] code;
    logic       sink;
    logic       off;
    int         n;
    code = 3'h0;
    sink = 1'b0;
    off  = 1'b0;
    n    = 0;
    nxt_s = s_ff;
    // Write channel: address and data taken in either order
    if (axi_req_in.awvalid && s_ff.rsp.awready) begin
      nxt_s.aw_got       = 1'b1;
      nxt_s.aw_addr      = axi_req_in.awaddr;
      nxt_s.rsp.awready  = 1'b0;
    end
    if (axi_req_in.wvalid && s_ff.rsp.wready) begin
      nxt_s.w_got        = 1'b1;
      nxt_s.w_data       = axi_req_in.wdata;
      nxt_s.w_strb       = axi_req_in.wstrb;
      nxt_s.rsp.wready   = 1'b0;
    end
    case (s_ff.wst)
      WCU_W_IDLE: begin
        if (s_ff.aw_got && s_ff.w_got) begin
          if (s_ff.aw_addr[9:2] == WCU_REG_ADDR[9:2]) begin
            for (int b = 0; b < 3; b++) begin
              if (s_ff.w_strb[b]) begin
                nxt_s.cfg[8*b +: 8] = s_ff.w_data[8*b +: 8];
              end
            end
            // Reserved bit masked out of the store, so it can never read back set
            nxt_s.cfg = nxt_s.cfg & WCU_WRITE_MASK;
            nxt_s.rsp.bresp = WCU_RESP_OKAY;
          end else begin
            nxt_s.rsp.bresp = WCU_RESP_SLVERR;
          end
          nxt_s.rsp.bvalid = 1'b1;
          nxt_s.aw_got     = 1'b0;
          nxt_s.w_got      = 1'b0;
          nxt_s.wst        = WCU_W_RESP;
        end
      end
      WCU_W_RESP: begin
        if (axi_req_in.bready) begin
          nxt_s.rsp.bvalid  = 1'b0;
          nxt_s.rsp.awready = 1'b1;
          nxt_s.rsp.wready  = 1'b1;
          nxt_s.wst         = WCU_W_IDLE;
        end
      end
      default: nxt_s.wst = WCU_W_IDLE;
    endcase
    // Read channel
    case (s_ff.rst)
      WCU_R_IDLE: begin
        if (axi_req_in.arvalid) begin
          nxt_s.rsp.arready = 1'b0;
          nxt_s.rsp.rvalid  = 1'b1;
          if (axi_req_in.araddr[9:2] == WCU_REG_ADDR[9:2]) begin
            nxt_s.rsp.rdata = {8'h00, s_ff.cfg & WCU_WRITE_MASK};
            nxt_s.rsp.rresp = WCU_RESP_OKAY;
          end else begin
            nxt_s.rsp.rdata = 32'h00000000;
            nxt_s.rsp.rresp = WCU_RESP_SLVERR;
          end
          nxt_s.rst = WCU_R_DATA;
        end
      end
      WCU_R_DATA: begin
        if (axi_req_in.rready) begin
          nxt_s.rsp.rvalid  = 1'b0;
          nxt_s.rsp.arready = 1'b1;
          nxt_s.rst         = WCU_R_IDLE;
        end
      end
      default: nxt_s.rst = WCU_R_IDLE;
    endcase
    // Level per input, with closure reduction in continuous mode
    for (int i = 0; i < WCU_INPUTS; i++) begin
      n    = i + 12;
      code = field_of(s_ff.cfg, n);
      // Side taken from the pin; sel_sink_in high selects the sink disable bit
      sink = sel_sink_in[n];
      off  = sink ? s_ff.cfg[WCU_SINK_OFF_BIT] : s_ff.cfg[WCU_SRC_OFF_BIT];
      if (continuous_in && closed_in[n] && !off && code >= WCU_CODE_10MA) begin
        nxt_s.level[6*i +: 6] = WCU_LVL_2MA;
      end else begin
        nxt_s.level[6*i +: 6] = decode(code);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff             <= '0;
      s_ff.wst         <= WCU_W_IDLE;
      s_ff.rst         <= WCU_R_IDLE;
      s_ff.cfg         <= WCU_RESET_VAL;
      s_ff.rsp.awready <= 1'b1;
      s_ff.rsp.wready  <= 1'b1;
      s_ff.rsp.arready <= 1'b1;
      s_ff.level       <= {WCU_INPUTS{WCU_LVL_OFF}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign axi_rsp_out = s_ff.rsp;
  assign level_out   = s_ff.level;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !s_ff.cfg[23]) else $error("reserved bit set");
  read_reserved_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_ff.rsp.rvalid |-> s_ff.rsp.rdata[31:23] == 9'h000) else $error("reserved read nonzero");
  write_store_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.wst == WCU_W_IDLE && s_ff.aw_got && s_ff.w_got && s_ff.aw_addr == WCU_REG_ADDR
     && s_ff.w_strb == 4'hF) |=> s_ff.cfg == ($past(s_ff.w_data[23:0]) & WCU_WRITE_MASK))
    else $error("write not stored");
  bad_addr_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.rst == WCU_R_IDLE && axi_req_in.arvalid && axi_req_in.araddr[9:2] != WCU_REG_ADDR[9:2])
    |=> s_ff.rsp.rresp == WCU_RESP_SLVERR) else $error("unmapped read not refused");
  code_map_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!continuous_in && $stable(s_ff.cfg)) |=> s_ff.level[71:66] == decode($past(s_ff.cfg[20:18])))
    else $error("input 23 level wrong");
  sink_reduce_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (continuous_in && closed_in[12] && sel_sink_in[12] && !s_ff.cfg[22] && s_ff.cfg[2])
    |=> s_ff.level[5:0] == WCU_LVL_2MA) else $error("sink reduction missing");
  src_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (continuous_in && closed_in[12] && !sel_sink_in[12] && s_ff.cfg[21] && s_ff.cfg[2:0] == 3'h4)
    |=> s_ff.level[5:0] == WCU_LVL_10MA) else $error("source reduction not disabled");
  pair_share_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!continuous_in && $stable(s_ff.cfg)) |=> s_ff.level[5:0] == s_ff.level[11:6])
    else $error("pair levels differ");
  bresp_bound_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.aw_got && s_ff.w_got) |-> ##[1:2] s_ff.rsp.bvalid) else $error("no write response");

  ////////////////////////////////////////////////////////////////////////
  // Field to input mapping, no reduction outside continuous mode
  level_in22_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[65:60] == decode($past(s_ff.cfg[17:15])))
    else $error("input 22 level wrong");
  level_in20_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[53:48] == decode($past(s_ff.cfg[14:12])))
    else $error("input 20 level wrong");
  level_in18_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[41:36] == decode($past(s_ff.cfg[11:9])))
    else $error("input 18 level wrong");
  level_in16_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[29:24] == decode($past(s_ff.cfg[8:6])))
    else $error("input 16 level wrong");
  level_in14_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[17:12] == decode($past(s_ff.cfg[5:3])))
    else $error("input 14 level wrong");
  level_in12_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[5:0] == decode($past(s_ff.cfg[2:0])))
    else $error("input 12 level wrong");
  pair_14_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[17:12] == s_ff.level[23:18])
    else $error("pair 14 levels differ");
  pair_16_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[29:24] == s_ff.level[35:30])
    else $error("pair 16 levels differ");
  pair_18_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[41:36] == s_ff.level[47:42])
    else $error("pair 18 levels differ");
  pair_20_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !continuous_in
    |=> s_ff.level[53:48] == s_ff.level[59:54])
    else $error("pair 20 levels differ");
  level_onehot_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $onehot(s_ff.level[71:66]) && $onehot(s_ff.level[5:0]))
    else $error("level not one-hot");

  ////////////////////////////////////////////////////////////////////////
  // Closure reduction, both sides, both disable bits
  sink_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (continuous_in && closed_in[12] && sel_sink_in[12] && s_ff.cfg[22])
    |=> s_ff.level[5:0] == decode($past(s_ff.cfg[2:0])))
    else $error("sink reduction not disabled");
  src_reduce_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (continuous_in && closed_in[12] && !sel_sink_in[12] && !s_ff.cfg[21] && s_ff.cfg[2])
    |=> s_ff.level[5:0] == WCU_LVL_2MA)
    else $error("source reduction missing");
  in23_reduce_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (continuous_in && closed_in[23] && !sel_sink_in[23] && !s_ff.cfg[21] && s_ff.cfg[20])
    |=> s_ff.level[71:66] == WCU_LVL_2MA)
    else $error("input 23 reduction missing");
  in22_reduce_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (continuous_in && closed_in[22] && sel_sink_in[22] && !s_ff.cfg[22] && s_ff.cfg[17])
    |=> s_ff.level[65:60] == WCU_LVL_2MA)
    else $error("input 22 reduction missing");
  open_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !closed_in[13]
    |=> s_ff.level[11:6] == decode($past(s_ff.cfg[2:0])))
    else $error("open input reduced");
  low_code_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !s_ff.cfg[20]
    |=> s_ff.level[71:66] == decode($past(s_ff.cfg[20:18])))
    else $error("low code reduced");

  ////////////////////////////////////////////////////////////////////////
  // Register bus handshakes; a held answer must not change under the master
  bvalid_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.rsp.bvalid && !axi_req_in.bready)
    |=> s_ff.rsp.bvalid && $stable(s_ff.rsp.bresp))
    else $error("write response dropped");
  b_done_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.rsp.bvalid && axi_req_in.bready)
    |=> !s_ff.rsp.bvalid && s_ff.rsp.awready && s_ff.rsp.wready)
    else $error("write not released");
  w_block_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_ff.rsp.bvalid |-> !s_ff.rsp.awready && !s_ff.rsp.wready)
    else $error("second write accepted");
  rvalid_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.rsp.rvalid && !axi_req_in.rready)
    |=> s_ff.rsp.rvalid && $stable(s_ff.rsp.rdata))
    else $error("read data dropped");
  r_block_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_ff.rsp.rvalid |-> !s_ff.rsp.arready)
    else $error("second read accepted");
  rd_data_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.rst == WCU_R_IDLE && axi_req_in.arvalid
     && axi_req_in.araddr[9:2] == WCU_REG_ADDR[9:2])
    |=> s_ff.rsp.rvalid && s_ff.rsp.rresp == WCU_RESP_OKAY
        && s_ff.rsp.rdata == {8'h00, $past(s_ff.cfg) & WCU_WRITE_MASK})
    else $error("read data wrong");
  wr_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_ff.wst == WCU_W_IDLE && s_ff.aw_got && s_ff.w_got
     && s_ff.aw_addr[9:2] != WCU_REG_ADDR[9:2])
    |=> s_ff.rsp.bresp == WCU_RESP_SLVERR && $stable(s_ff.cfg))
    else $error("unmapped write stored");

  bad_cover_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_ff.rsp.bvalid && s_ff.rsp.bresp == WCU_RESP_SLVERR);
  wr_cover_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_ff.rsp.bvalid && axi_req_in.bready);
  rd_cover_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_ff.rsp.rvalid && axi_req_in.rready && s_ff.rsp.rresp == WCU_RESP_OKAY);
  red_cover_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_ff.level[5:0] == WCU_LVL_2MA && s_ff.cfg[2]);
endmodule

// [test/wcu_tb.sv]
// Testbench: random and corner checks of the upper wetting current register
`timescale 1ns/1ps
module tb;
  import wcu_pkg::*;
  logic                  clk_sys_in;
  logic                  rst_n_in;
  wcu_axi_req_t          req;
  wcu_axi_rsp_t          rsp;
  logic [23:0]           sel_sink_in;
  logic [23:0]           closed_in;
  logic                  continuous_in;
  logic [71:0]           level_out;
  int                    err_count;
  int                    samples_checked;
  logic [15:0]           seed;
  logic [31:0]           d;
  logic [31:0]           dat;
  logic [1:0]            r;

  wcu_top DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .axi_req_in(req),
    .axi_rsp_out(rsp), .sel_sink_in(sel_sink_in), .closed_in(closed_in),
    .continuous_in(continuous_in), .level_out(level_out));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected one-hot level for all twelve inputs
  function automatic logic [71:0] exp_lvl(input logic [23:0] c, input logic [23:0] snk,
                                          input logic [23:0] cl, input logic ct);
    logic [2:0] code;
    logic [5:0] l;
    exp_lvl = '0;
    for (int n = 0; n < 12; n++) begin
      code = (n == 11) ? c[20:18] : (n == 10) ? c[17:15] : c[3*(n/2) +: 3];
      case (code)
        3'h0: l = WCU_LVL_OFF;
        3'h1: l = WCU_LVL_1MA;
        3'h2: l = WCU_LVL_2MA;
        3'h3: l = WCU_LVL_5MA;
        3'h4: l = WCU_LVL_10MA;
        default: l = WCU_LVL_15MA;
      endcase
      // Side picks which disable bit applies
      if (ct && cl[n+12] && code >= WCU_CODE_10MA && !c[snk[n+12] ? 22 : 21]) l = WCU_LVL_2MA;
      exp_lvl[6*n +: 6] = l;
    end
  endfunction

  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys_in);
    req.awaddr <= a; req.awvalid <= 1'b1; req.wdata <= v;
    req.wstrb <= 4'hF; req.wvalid <= 1'b1; req.bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys_in);
      if (req.awvalid && rsp.awready === 1'b1) begin req.awvalid <= 1'b0; aw_ok = 1'b1; end
      if (req.wvalid && rsp.wready === 1'b1) begin req.wvalid <= 1'b0; w_ok = 1'b1; end
    end
    do @(posedge clk_sys_in); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_sys_in);
    req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
    do @(posedge clk_sys_in); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_sys_in); while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0; samples_checked = 0; seed = 16'hF02A;
    req = '0; sel_sink_in = '0; closed_in = '0; continuous_in = 1'b0; rst_n_in = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    chk("level_reset", level_out, {12{WCU_LVL_OFF}});
    rd(WCU_REG_ADDR, d, r);
    chk("rd_reset", d, 72'h0);
    chk("rresp_reset", r, WCU_RESP_OKAY);
    $display("Test reset done");
    wr(WCU_REG_ADDR, 32'hFFFFFFFF, r);
    rd(WCU_REG_ADDR, d, r);
    chk("rd_ones", d, 72'h7FFFFF);
    $display("Test reserved bit done");
    wr(WCU_REG_ADDR + 10'h004, 32'h0, r);
    chk("bresp_unmapped", r, WCU_RESP_SLVERR);
    rd(WCU_REG_ADDR + 10'h004, d, r);
    chk("rresp_unmapped", r, WCU_RESP_SLVERR);
    rd(WCU_REG_ADDR, d, r);
    chk("rd_no_store", d, 72'h7FFFFF);
    $display("Test unmapped done");
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed); dat[15:0] = seed;
      seed = lfsr(seed); dat[31:16] = seed;
      seed = lfsr(seed);
      if (i < 8) begin
        dat[23:0] = {dat[23], i[1:0], {7{i[2:0]}}};
        closed_in <= 24'hFFFFFF;
        continuous_in <= 1'b1;
      end else begin
        closed_in <= {seed[11:0], seed[15:4]};
        continuous_in <= seed[0];
      end
      sel_sink_in <= {dat[7:0], seed};
      wr(WCU_REG_ADDR, dat, r);
      chk("bresp_ok", r, WCU_RESP_OKAY);
      rd(WCU_REG_ADDR, d, r);
      chk("rd_back", d, {48'h0, dat[23:0] & WCU_WRITE_MASK});
      repeat (2) @(posedge clk_sys_in);
      chk("level", level_out, exp_lvl(dat[23:0] & WCU_WRITE_MASK, sel_sink_in, closed_in,
                                      continuous_in));
    end
    $display("Test random levels done");
    final_report();
  end
endmodule
